// [design/trg_core.sv]
/*
   trigger mode, arming, auto trigger and run sequencing with an apb
   register file; assumes comparator outputs and the arm pin are
   asynchronous, analyzer arm and status signals run on clock_i
*/
`timescale 1ns/1ps
`include "trg_regs.svh"

// Contract
// - mode toggles edge/self, edge after reset
// - self mode triggers once arming is met
// - free run acquires unsynchronized, continuously when repetitive
// - external arm triggers at once in self
// - analyzer machine arm triggers in self
// - arm source defaults to free run
// - edge mode triggers on selected crossing
// - edge source toggles, channel one default
// - knob steps one percent, window clamped
// - level outside waveform gives no trigger
// - level resets to logic threshold preset
// - slope toggles, positive after reset
// - timeout presents memory, flags auto
// - timeout off waits, flags waiting
// - single run makes one acquisition
// - repetitive runs until stop command
// - run mode single at reset, toggles
// - repetitive start waits for analyzers
// - delay beyond five divisions: off screen
module trg_core
#(
   parameter int TICK_CYC   = `TRG_TICK_NS / `TRG_CLK_NS,
   parameter int AUTO_TICKS = `TRG_AUTO_S * (`TRG_S_NS / `TRG_TICK_NS)
)
(
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   input  wire logic [7:0]        paddr_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   input  wire logic              comp1_i,
   input  wire logic              comp2_i,
   input  wire logic              external_arm_input_i,
   input  wire logic              mach1_arm_i,
   input  wire logic              mach2_arm_i,
   input  wire logic [1:0]        ana_enabled_i,
   input  wire logic [1:0]        ana_done_i,
   output logic      [15:0]       level_o,
   output logic                   trig_o,
   output logic                   present_o,
   output logic                   synced_o,
   output logic                   auto_trig_o,
   output logic                   waiting_o,
   output logic                   offscreen_o,
   output logic                   running_o,
   output trg_pkg::trg_state_t    state_o
);
   import trg_pkg::*;

   localparam int AW = $clog2(AUTO_TICKS + 1);

   // one percent of four divisions
   function automatic logic [17:0] step_of(input logic [15:0] v);
      logic [17:0] p;
      p = 18'({2'b00, v}) * `TRG_FULL_DIV;
      return p / `TRG_PCT;
   endfunction

   // confine a level to plus and minus two divisions
   function automatic logic [15:0] clamp(input logic signed [17:0] v,
                                         input logic signed [17:0] lim);
      logic signed [17:0] r;
      r = v;
      if (v > lim)
         r = lim;
      if (v < -lim)
         r = -lim;
      return r[15:0];
   endfunction

   // settings
   logic               mode_self;
   trg_arm_t           arm_source_select;
   logic               esrc;
   logic               slope_neg;
   logic               auto_en;
   logic               rmode_rep;
   logic        [15:0] vdiv;
   logic signed [31:0] delay;
   logic        [31:0] sweep;

   // sequence state
   trg_state_t         state;
   trg_state_t         next_state;
   logic               pending;
   logic      [AW-1:0] tmo_cnt;
   logic               sel_prev;

   // synchronized pins
   logic               c1_s;
   logic               c2_s;
   logic               ext_s;
   logic               tick;

   // bus decode
   wire acc   = psel_i && penable_i;
   wire setup = psel_i && !penable_i;
   wire wr    = acc && pwrite_i;
   wire h_ctrl = (paddr_i == `TRG_A_CTRL);
   wire h_tog  = (paddr_i == `TRG_A_TOGGLE);
   wire h_cmd  = (paddr_i == `TRG_A_CMD);
   wire h_lvl  = (paddr_i == `TRG_A_LEVEL);
   wire h_knob = (paddr_i == `TRG_A_KNOB);
   wire h_vdiv = (paddr_i == `TRG_A_VDIV);
   wire h_dly  = (paddr_i == `TRG_A_DELAY);
   wire h_swp  = (paddr_i == `TRG_A_SWEEP);
   wire h_stat = (paddr_i == `TRG_A_STATUS);
   wire mapped = h_ctrl || h_tog || h_cmd || h_lvl || h_knob ||
                 h_vdiv || h_dly || h_swp || h_stat;

   // zero wait states, error on unmapped offsets
   assign pready_o  = 1'b1;
   assign pslverr_o = acc && !mapped;

   // command strobes; stop beats run in one write
   wire cmd_stop = wr && h_cmd && pwdata_i[`TRG_B_STOP];
   wire cmd_run  = wr && h_cmd && pwdata_i[`TRG_B_RUN] && !cmd_stop;
   wire tog      = wr && h_tog;

   // level knob arithmetic
   wire        [17:0] step  = step_of(vdiv);
   wire signed [17:0] lim   = $signed({1'b0, vdiv, 1'b0});
   wire signed [17:0] lvl18 = {{2{level_o[15]}}, level_o};
   wire signed [17:0] wr18  = {{2{pwdata_i[15]}}, pwdata_i[15:0]};
   wire signed [17:0] up18  = lvl18 + $signed(step);
   wire signed [17:0] dn18  = lvl18 - $signed(step);
   wire        [15:0] lvl_up = clamp(up18, lim);
   wire        [15:0] lvl_dn = clamp(dn18, lim);
   wire        [15:0] lvl_wr = clamp(wr18, lim);

   // off screen compare on delay magnitude
   wire [31:0] dmag  = delay[31] ? 32'(-delay) : 32'(delay);
   wire [35:0] lim5  = 36'(sweep) * `TRG_OFF_DIV;
   wire        over5 = (36'(dmag) > lim5);

   // edge of the chosen comparator in the chosen direction
   wire sel_now  = esrc ? c2_s : c1_s;
   wire rise     = sel_now && !sel_prev;
   wire fall     = !sel_now && sel_prev;
   wire edge_hit = slope_neg ? fall : rise;

   // arming and trigger decision
   wire armed = (arm_source_select == ARM_RUN) ||
                (arm_source_select == ARM_EXT && ext_s) ||
                (arm_source_select == ARM_M1 && mach1_arm_i) ||
                (arm_source_select == ARM_M2 && mach2_arm_i);
   wire free_run = mode_self && (arm_source_select == ARM_RUN);
   wire trig_now = !free_run && armed && (mode_self || edge_hit);
   wire timeout  = auto_en && (tmo_cnt == AW'(AUTO_TICKS));
   wire in_wait  = (state == ST_WAIT);
   wire go       = in_wait && (trig_now || free_run || timeout);
   wire ana_ok   = &(~ana_enabled_i | ana_done_i);
   wire start_ok = pending && (!rmode_rep || ana_ok);
   wire enter_w  = (next_state == ST_WAIT) && (state != ST_WAIT);

   // sequence transitions
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE:
            if (start_ok && !cmd_stop)
               next_state = ST_WAIT;
         ST_WAIT:
            if (cmd_stop)
               next_state = ST_IDLE;
            else if (go)
               next_state = ST_SHOW;
         ST_SHOW:
            if (cmd_stop || !rmode_rep)
               next_state = ST_IDLE;
            else
               next_state = ST_WAIT;
         default:
            next_state = ST_IDLE;
      endcase
   end

   // pin synchronizers
   trg_sync3 u_sync_c1
   (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .d_i     (comp1_i),
      .q_o     (c1_s)
   );

   trg_sync3 u_sync_c2
   (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .d_i     (comp2_i),
      .q_o     (c2_s)
   );

   trg_sync3 u_sync_ext
   (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .d_i     (external_arm_input_i),
      .q_o     (ext_s)
   );

   // timeout prescaler restarted with each attempt
   trg_tick #(.CYC(TICK_CYC)) u_tick
   (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .clear_i (enter_w),
      .tick_o  (tick)
   );

   // trigger settings, written whole or, except the arm source, toggled bit by bit
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mode_self         <= 1'b0;
         arm_source_select <= ARM_RUN;
         esrc              <= 1'b0;
         slope_neg         <= 1'b0;
         auto_en           <= `TRG_AUTO_RST;
         rmode_rep         <= 1'b0;
      end
      else if (wr && h_ctrl)
      begin
         mode_self         <= pwdata_i[`TRG_B_MODE];
         arm_source_select <= trg_arm_t'(pwdata_i[`TRG_B_ARM +: 2]);
         esrc              <= pwdata_i[`TRG_B_ESRC];
         slope_neg         <= pwdata_i[`TRG_B_SLOPE];
         auto_en           <= pwdata_i[`TRG_B_AUTO];
         rmode_rep         <= pwdata_i[`TRG_B_RMODE];
      end
      else if (tog)
      begin
         mode_self <= mode_self ^ pwdata_i[`TRG_B_MODE];
         esrc      <= esrc ^ pwdata_i[`TRG_B_ESRC];
         slope_neg <= slope_neg ^ pwdata_i[`TRG_B_SLOPE];
         auto_en   <= auto_en ^ pwdata_i[`TRG_B_AUTO];
         rmode_rep <= rmode_rep ^ pwdata_i[`TRG_B_RMODE];
      end
   end

   // level, scale, delay and sweep
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         level_o <= `TRG_LEVEL_RST;
         vdiv    <= `TRG_VDIV_RST;
         delay   <= '0;
         sweep   <= '0;
      end
      else
      begin
         if (wr && h_lvl)
            level_o <= lvl_wr;
         else if (wr && h_knob && pwdata_i[`TRG_B_UP])
            level_o <= lvl_up;
         else if (wr && h_knob && pwdata_i[`TRG_B_DOWN])
            level_o <= lvl_dn;
         if (wr && h_vdiv)
            vdiv <= pwdata_i[15:0];
         if (wr && h_dly)
            delay <= pwdata_i;
         if (wr && h_swp)
            sweep <= pwdata_i;
      end
   end

   // run request held until it may start; run set beats start clear
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         pending <= 1'b0;
      else if (cmd_stop)
         pending <= 1'b0;
      else if (cmd_run && state == ST_IDLE)
         pending <= 1'b1;
      else if (state == ST_IDLE && start_ok)
         pending <= 1'b0;
   end

   // sequence state and edge history
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state    <= ST_IDLE;
         sel_prev <= 1'b0;
      end
      else
      begin
         state    <= next_state;
         sel_prev <= sel_now;
      end
   end

   // timeout counter, cleared on each new attempt
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         tmo_cnt <= '0;
      else if (enter_w)
         tmo_cnt <= '0;
      else if (in_wait && tick && !timeout)
         tmo_cnt <= tmo_cnt + 1'b1;
   end

   // result outputs
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         trig_o      <= 1'b0;
         present_o   <= 1'b0;
         synced_o    <= 1'b0;
         auto_trig_o <= 1'b0;
         waiting_o   <= 1'b0;
         offscreen_o <= 1'b0;
         running_o   <= 1'b0;
      end
      else
      begin
         trig_o      <= go && trig_now;
         present_o   <= go && !cmd_stop;
         if (go && !cmd_stop)
         begin
            synced_o    <= trig_now;
            auto_trig_o <= !trig_now && !free_run;
         end
         waiting_o   <= (next_state == ST_WAIT) && !auto_en;
         offscreen_o <= over5;
         running_o   <= (next_state != ST_IDLE);
      end
   end

   // read data selection by offset
   wire [31:0] ctrl_val = {25'h0, rmode_rep, auto_en, slope_neg, esrc,
                           arm_source_select, mode_self};
   wire [31:0] stat_val = {26'h0, pending, synced_o, offscreen_o,
                           waiting_o, auto_trig_o, running_o};
   wire [31:0] rd_val   = h_ctrl ? ctrl_val :
                          h_lvl  ? {{16{level_o[15]}}, level_o} :
                          h_vdiv ? {16'h0, vdiv} :
                          h_dly  ? delay :
                          h_swp  ? sweep :
                          h_stat ? stat_val : 32'h0;

   // read data captured in the setup phase
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         prdata_o <= '0;
      else if (setup && !pwrite_i)
         prdata_o <= rd_val;
   end

   assign state_o = state;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_self;
      in_wait && mode_self && !cmd_stop && !free_run && armed
      |=> trig_o && present_o && synced_o;
   endproperty
   a_self: assert property (p_self)
      else $error("self mode did not trigger when armed");

   property p_ext;
      in_wait && mode_self && arm_source_select == ARM_EXT &&
      ext_s && !cmd_stop |=> trig_o;
   endproperty
   a_ext: assert property (p_ext)
      else $error("external arm did not trigger");

   property p_mach;
      in_wait && mode_self && !cmd_stop &&
      ((arm_source_select == ARM_M1 && mach1_arm_i) ||
       (arm_source_select == ARM_M2 && mach2_arm_i)) |=> trig_o;
   endproperty
   a_mach: assert property (p_mach)
      else $error("analyzer arm did not trigger");

   property p_edge;
      trig_o && !$past(mode_self) |-> $past(edge_hit, 1);
   endproperty
   a_edge: assert property (p_edge)
      else $error("edge trigger without a crossing");

   property p_free;
      in_wait && free_run && !cmd_stop
      |=> present_o && !synced_o && !trig_o;
   endproperty
   a_free: assert property (p_free)
      else $error("free run acquisition not presented unsynced");

   property p_single;
      state == ST_SHOW && !rmode_rep |=> state == ST_IDLE ##1
      (state == ST_IDLE || $past(start_ok));
   endproperty
   a_single: assert property (p_single)
      else $error("single run did not stop");

   property p_rep;
      state == ST_SHOW && rmode_rep && !cmd_stop |=> in_wait;
   endproperty
   a_rep: assert property (p_rep)
      else $error("repetitive run did not continue");

   property p_hold;
      state == ST_IDLE && rmode_rep && !ana_ok |=> state == ST_IDLE;
   endproperty
   a_hold: assert property (p_hold)
      else $error("repetitive run started with busy analyzer");

   property p_wait;
      in_wait && !auto_en && !go ##1 in_wait |-> waiting_o;
   endproperty
   a_wait: assert property (p_wait)
      else $error("waiting indication missing");

   property p_tmo;
      in_wait && timeout && !trig_now && !free_run && !cmd_stop
      |=> present_o && auto_trig_o && !synced_o;
   endproperty
   a_tmo: assert property (p_tmo)
      else $error("timeout did not present auto triggered");

   property p_off;
      $changed(sweep) || $changed(delay) |=> offscreen_o == over5;
   endproperty
   a_off: assert property (p_off)
      else $error("off screen flag wrong");

endmodule

// [common/trg_regs.svh]
/*
   register map, field positions, reset values and timing figures
   of the trigger sequencer; included by the core only
*/
`ifndef TRG_REGS_SVH
`define TRG_REGS_SVH

// byte offsets on the apb bus
`define TRG_A_CTRL    8'h00
`define TRG_A_TOGGLE  8'h04
`define TRG_A_CMD     8'h08
`define TRG_A_LEVEL   8'h0C
`define TRG_A_KNOB    8'h10
`define TRG_A_VDIV    8'h14
`define TRG_A_DELAY   8'h18
`define TRG_A_SWEEP   8'h1C
`define TRG_A_STATUS  8'h20

// ctrl and toggle fields
`define TRG_B_MODE    0
`define TRG_B_ARM     1
`define TRG_B_ESRC    3
`define TRG_B_SLOPE   4
`define TRG_B_AUTO    5
`define TRG_B_RMODE   6

// command and knob strobes
`define TRG_B_RUN     0
`define TRG_B_STOP    1
`define TRG_B_UP      0
`define TRG_B_DOWN    1

// status fields
`define TRG_B_RUNNING 0
`define TRG_B_AUTOTRG 1
`define TRG_B_WAITING 2
`define TRG_B_OFFSCR  3
`define TRG_B_SYNCED  4
`define TRG_B_PENDING 5

// reset values, level in signed mv, vdiv in mv
`define TRG_LEVEL_RST 16'h0654
`define TRG_VDIV_RST  16'h03E8
`define TRG_AUTO_RST  1'b1

// scale figures
`define TRG_FULL_DIV  18'h4
`define TRG_PCT       18'h64
`define TRG_HALF_DIV  1
`define TRG_OFF_DIV   36'h5

// timing: clock period, prescaler tick, auto trigger wait
`define TRG_CLK_NS    20
`define TRG_TICK_NS   1000000
`define TRG_AUTO_S    1
`define TRG_S_NS      1000000000

`endif

// [common/trg_pkg.sv]
/*
   types shared by the trigger sequencer files
   assumes nothing beyond a systemverilog compiler
*/
package trg_pkg;

   // acquisition sequence, gray along idle, wait, show
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_SHOW = 2'b11
   } trg_state_t;

   // arming source choices
   typedef enum logic [1:0]
   {
      ARM_RUN = 2'b00,
      ARM_EXT = 2'b01,
      ARM_M1  = 2'b10,
      ARM_M2  = 2'b11
   } trg_arm_t;

endpackage

// [design/trg_sync3.sv]
/*
   three flip-flop synchroniser for a pin level
   assumes d_i is asynchronous to clock_i
*/
`timescale 1ns/1ps

module trg_sync3
(
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   input  wire logic d_i,
   output logic      q_o
);

   logic s1;
   logic s2;
   logic s3;

   // s1 feeds s2 only; a change counts once s2 and s3 agree
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s1  <= 1'b0;
         s2  <= 1'b0;
         s3  <= 1'b0;
         q_o <= 1'b0;
      end
      else
      begin
         s1 <= d_i;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            q_o <= s3;
      end
   end

endmodule

// [design/trg_tick.sv]
/*
   prescaler giving a one-cycle tick every CYC clocks
   assumes clear_i restarts the count from zero
*/
`timescale 1ns/1ps

module trg_tick
#(
   parameter int CYC = 50000
)
(
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   input  wire logic clear_i,
   output logic      tick_o
);

   localparam int W = $clog2(CYC + 1);

   logic [W-1:0] cnt;
   wire          wrap = (cnt == W'(CYC - 1));

   // count clocks, pulse on wrap
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt    <= '0;
         tick_o <= 1'b0;
      end
      else
      begin
         cnt    <= (clear_i || wrap) ? '0 : cnt + 1'b1;
         tick_o <= wrap && !clear_i;
      end
   end

endmodule

// [sim/trg_panel_model.sv]
/*
   far side of the trigger sequencer: comparators, arm pin, analyzers
   assumes the bench changes pins_i just after a rising clock edge
*/
`timescale 1ns/1ps

module trg_panel_model
(
   input  wire logic       clock_i,
   input  wire logic [8:0] pins_i,
   output logic            comp1_o,
   output logic            comp2_o,
   output logic            ext_arm_o,
   output logic            mach1_arm_o,
   output logic            mach2_arm_o,
   output logic [1:0]      ana_enabled_o,
   output logic [1:0]      ana_done_o
);
   // pin levels applied on the next rising edge
   always_ff @(posedge clock_i)
   begin
      comp1_o       <= pins_i[0];
      comp2_o       <= pins_i[1];
      ext_arm_o     <= pins_i[2];
      mach1_arm_o   <= pins_i[3];
      mach2_arm_o   <= pins_i[4];
      ana_enabled_o <= pins_i[6:5];
      ana_done_o    <= pins_i[8:7];
   end
endmodule

// [sim/scope_trigger_arm_control_tb.sv]
/*
   self-checking bench of the trigger sequencer over apb
   assumes zero wait states are not relied on and short timeout figures
*/
`timescale 1ns/1ps

module scope_trigger_arm_control_tb;
   import trg_pkg::*;
   logic              clock_i, rst_n_i, psel_i, penable_i, pwrite_i;
   logic [7:0]        paddr_i;
   logic [31:0]       pwdata_i, prdata_o, rd;
   logic              pready_o, pslverr_o, last_err;
   logic              c1, c2, ext, m1, m2;
   logic [1:0]        en, dn;
   logic [8:0]        pins;
   logic [15:0]       level_o;
   logic              trig_o, present_o, synced_o, auto_trig_o;
   logic              waiting_o, offscreen_o, running_o;
   trg_state_t        state_o;
   int                fail_count, total_checks, k;

   trg_core #(.TICK_CYC(4), .AUTO_TICKS(8)) i_trg_core
   (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .comp1_i(c1), .comp2_i(c2),
      .external_arm_input_i(ext), .mach1_arm_i(m1), .mach2_arm_i(m2),
      .ana_enabled_i(en), .ana_done_i(dn), .level_o(level_o),
      .trig_o(trig_o), .present_o(present_o), .synced_o(synced_o),
      .auto_trig_o(auto_trig_o), .waiting_o(waiting_o),
      .offscreen_o(offscreen_o), .running_o(running_o), .state_o(state_o)
   );

   trg_panel_model i_trg_panel_model
   (
      .clock_i(clock_i), .pins_i(pins), .comp1_o(c1), .comp2_o(c2),
      .ext_arm_o(ext), .mach1_arm_o(m1), .mach2_arm_o(m2),
      .ana_enabled_o(en), .ana_done_o(dn)
   );

   // 50 MHz clock
   initial
   begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one apb transfer, held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clock_i);
      psel_i <= 1'b1; penable_i <= 1'b0; paddr_i <= a;
      pwrite_i <= w; pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (pready_o !== 1'b1)
      begin
         fail_count++;
         report_and_stop();
      end
      rd = prdata_o;
      last_err = pslverr_o;
      psel_i <= 1'b0; penable_i <= 1'b0;
   endtask

   // wait on 0 trig, 1 present, 2 waiting, 3 running, bounded
   task automatic wt(input int s, input int lim);
      logic v;
      for (int n = 0; n <= lim; n++)
      begin
         @(posedge clock_i);
         #1;
         v = (s == 0) ? trig_o : (s == 1) ? present_o :
             (s == 2) ? waiting_o : running_o;
         if (v === 1'b1)
            return;
      end
      fail_count++;
      report_and_stop();
   endtask

   task automatic run_single(input logic [31:0] ctrl);
      apb(1'b1, 8'h00, ctrl);
      apb(1'b1, 8'h08, 32'h0000_0001);
   endtask

   // far side pin levels, changed just after an edge
   task automatic set_pins(input logic [8:0] v);
      @(posedge clock_i);
      pins <= v;
   endtask

   initial
   begin
      rst_n_i = 1'b0; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
      paddr_i = 8'h00; pwdata_i = 32'h0; fail_count = 0; total_checks = 0;
      pins = 9'h000;
      repeat (20) @(posedge clock_i);
      rst_n_i <= 1'b1;
      // reset values and unmapped access
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0000_0020);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'h0000_0654);
      chk(level_o, 16'h0654);
      apb(1'b0, 8'h24, 32'h0);
      chk(rd, 32'h0);
      chk(last_err, 1'b1);
      // toggles flip mode, source, slope and run mode, then flip them back along with auto
      apb(1'b1, 8'h04, 32'h0000_0059);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0000_0079);
      apb(1'b1, 8'h04, 32'h0000_0079);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0000_0000);
      // knob moves one percent of four divisions, window clamps
      apb(1'b1, 8'h10, 32'h0000_0001);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'h0000_067C);
      chk(level_o, 16'h067C);
      apb(1'b1, 8'h10, 32'h0000_0002);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'h0000_0654);
      apb(1'b1, 8'h0C, 32'h0000_1000);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'h0000_07D0);
      apb(1'b1, 8'h0C, 32'h0000_F000);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'hFFFF_F830);
      // self mode, external arm, single run then idle
      run_single(32'h0000_0003);
      wt(2, 20);
      chk(synced_o, 1'b0);
      set_pins(9'h004);
      wt(0, 20);
      chk(present_o, 1'b1);
      set_pins(9'h000);
      repeat (3) @(posedge clock_i);
      chk(state_o, ST_IDLE);
      // analyzer machine arms
      for (k = 2; k < 4; k++)
      begin
         run_single(32'h0000_0001 | (k << 1));
         wt(2, 20);
         set_pins(9'h008 << (k - 2));
         wt(0, 20);
         chk(synced_o, 1'b1);
         set_pins(9'h000);
      end
      // free run presents without a trigger
      run_single(32'h0000_0001);
      wt(1, 20);
      chk({trig_o, synced_o}, 2'b00);
      // edge mode, channel one rising, then channel two falling
      run_single(32'h0000_0000);
      wt(2, 20);
      set_pins(9'h001);
      wt(0, 20);
      chk(synced_o, 1'b1);
      set_pins(9'h002);
      run_single(32'h0000_0018);
      wt(2, 20);
      set_pins(9'h000);
      wt(0, 20);
      chk(synced_o, 1'b1);
      // no crossing, timeout presents memory
      run_single(32'h0000_0020);
      wt(1, 200);
      chk({trig_o, auto_trig_o, synced_o}, 3'b010);
      // repetitive start held while an analyzer is busy
      set_pins(9'h020);
      run_single(32'h0000_0041);
      repeat (10) @(posedge clock_i);
      chk(running_o, 1'b0);
      set_pins(9'h0A0);
      wt(1, 20);
      wt(1, 20);
      chk(running_o, 1'b1);
      apb(1'b1, 8'h08, 32'h0000_0002);
      repeat (3) @(posedge clock_i);
      chk(state_o, ST_IDLE);
      // trigger marker off screen beyond five divisions
      apb(1'b1, 8'h1C, 32'h0000_000A);
      apb(1'b1, 8'h18, 32'h0000_0033);
      repeat (3) @(posedge clock_i);
      chk(offscreen_o, 1'b1);
      apb(1'b1, 8'h18, 32'h0000_0032);
      repeat (3) @(posedge clock_i);
      chk(offscreen_o, 1'b0);
      apb(1'b1, 8'h18, 32'hFFFF_FFCD);
      repeat (3) @(posedge clock_i);
      chk(offscreen_o, 1'b1);
      report_and_stop();
   end
endmodule
